// >>> hw/dps_regs.vh
// Constants for the dual-port synchronous memory with pass-through
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
`define DPS_ADDR_W 15
`define DPS_DATA_W 36
`define DPS_DEPTH 32768
`define DPS_FIFO_W 36
`define DPS_FIFO_D 4
`define DPS_FIFO_AW 2
`define DPS_DOUT_RST 36'h000000000
`define DPS_OP_IDLE 2'h0
`define DPS_OP_READ 2'h1
`define DPS_OP_FWD 2'h2
`endif

// >>> hw/dps_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dps_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    localparam [AW:0] FULL_CNT = DEPTH; // Word count that means full
    reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage words
    reg [AW-1:0] wrPtr_r; // Write index
    reg [AW-1:0] rdPtr_r; // Read index
    reg [AW:0] count_r; // Words held
    wire doPush; // Word accepted
    wire doPop; // Word drained
    assign inReady = (count_r != FULL_CNT);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData = mem_r[rdPtr_r];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    // Pointer and count update
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/dps_sram.v
// Dual-address dual-port synchronous memory with pass-through between ports
`timescale 1ns/100ps
`default_nettype none
`include "dps_regs.vh"
// Operation
// - Either chip select inactive deselects cycle
// - Deselected cycle does no access or forward
// - Port A write when its enable low
// - Port B write when its enable low
// - Forward A input to B output
// - Forward B input to A output
// - Port A read only when all high
// - Port B read only when all high
// - Writes and forwards combine freely
// - Write plus read, or two reads, concurrent
// - A-to-B forward suppresses reads
// - B-to-A forward suppresses reads
// - Data outputs high impedance at power-up
// - Same-address double write stores port B
// - Same-address read returns old contents
// - Output enables act asynchronously, active low
// - 15-bit addresses, 36-bit registered data paths
module dps_sram (
    input wire clk,
    input wire rst,
    input wire chip_select_low_active,
    input wire chip_select_high_active,
    input wire port_a_write_enable_n,
    input wire port_b_write_enable_n,
    input wire forward_a_to_b_n,
    input wire forward_b_to_a_n,
    input wire port_a_output_enable_n,
    input wire port_b_output_enable_n,
    input wire [`DPS_ADDR_W-1:0] port_a_address,
    input wire [`DPS_ADDR_W-1:0] port_b_address,
    input wire [`DPS_DATA_W-1:0] port_a_data_bus_in,
    output wire [`DPS_DATA_W-1:0] port_a_data_bus_out,
    output wire port_a_data_bus_oe,
    input wire [`DPS_DATA_W-1:0] port_b_data_bus_in,
    output wire [`DPS_DATA_W-1:0] port_b_data_bus_out,
    output wire port_b_data_bus_oe,
    output wire powerDown,
    output wire fwdValid,
    input wire fwdReady,
    output wire [`DPS_DATA_W-1:0] fwdData,
    output wire fwdInReady
);
    // Two-stage synchronisers for pin inputs
    reg [7:0] ctlS1_r; // First stage, control pins
    reg [7:0] ctlS2_r; // Second stage, control pins
    reg [`DPS_ADDR_W-1:0] addrAS1_r, addrAS2_r; // Port A address stages
    reg [`DPS_ADDR_W-1:0] addrBS1_r, addrBS2_r; // Port B address stages
    reg [`DPS_DATA_W-1:0] dinAS1_r, dinAS2_r; // Port A data stages
    reg [`DPS_DATA_W-1:0] dinBS1_r, dinBS2_r; // Port B data stages
    reg [`DPS_DATA_W-1:0] mem_r [0:`DPS_DEPTH-1]; // Array
    reg [`DPS_DATA_W-1:0] doutA_r; // Port A output register
    reg [`DPS_DATA_W-1:0] doutB_r; // Port B output register
    reg drvA_r; // Port A holds valid cycle data
    reg drvB_r; // Port B holds valid cycle data
    reg powerDown_r; // Deselected state
    reg [1:0] opA_r; // Last port A output source
    reg [1:0] opB_r; // Last port B output source
    wire sel; // Device selected this edge
    wire wrA, wrB, fwdAB, fwdBA, rdA, rdB; // Decoded operations
    // Pass control pins through two flops
    always @(posedge clk) begin
        ctlS1_r <= {chip_select_low_active, chip_select_high_active,
                    port_a_write_enable_n, port_b_write_enable_n,
                    forward_a_to_b_n, forward_b_to_a_n, 2'b00};
        ctlS2_r <= ctlS1_r;
        addrAS1_r <= port_a_address;
        addrAS2_r <= addrAS1_r;
        addrBS1_r <= port_b_address;
        addrBS2_r <= addrBS1_r;
        dinAS1_r <= port_a_data_bus_in;
        dinAS2_r <= dinAS1_r;
        dinBS1_r <= port_b_data_bus_in;
        dinBS2_r <= dinBS1_r;
    end
    // Cycle decode from synchronised controls
    assign sel = !ctlS2_r[7] && ctlS2_r[6];
    assign wrA = sel && !ctlS2_r[5];
    assign wrB = sel && !ctlS2_r[4];
    assign fwdAB = sel && !ctlS2_r[3];
    assign fwdBA = sel && !ctlS2_r[2];
    // Reads need both forwards idle
    assign rdA = sel && ctlS2_r[5] && ctlS2_r[3] && ctlS2_r[2];
    assign rdB = sel && ctlS2_r[4] && ctlS2_r[3] && ctlS2_r[2];
    // Array writes; port B write last so it wins on equal addresses
    always @(posedge clk) begin
        if (wrA) begin
            mem_r[addrAS2_r] <= dinAS2_r;
        end
        if (wrB) begin
            mem_r[addrBS2_r] <= dinBS2_r;
        end
    end
    // Output registers: read old contents, or forwarded data, one cycle later
    always @(posedge clk) begin
        if (rst) begin
            doutA_r <= `DPS_DOUT_RST;
            doutB_r <= `DPS_DOUT_RST;
            drvA_r <= 1'b0;
            drvB_r <= 1'b0;
            powerDown_r <= 1'b1;
            opA_r <= `DPS_OP_IDLE;
            opB_r <= `DPS_OP_IDLE;
        end else begin
            powerDown_r <= !sel;
            if (fwdBA) begin
                doutA_r <= dinBS2_r;
                opA_r <= `DPS_OP_FWD;
                drvA_r <= 1'b1;
            end else if (rdA) begin
                doutA_r <= mem_r[addrAS2_r];
                opA_r <= `DPS_OP_READ;
                drvA_r <= 1'b1;
            end
            if (fwdAB) begin
                doutB_r <= dinAS2_r;
                opB_r <= `DPS_OP_FWD;
                drvB_r <= 1'b1;
            end else if (rdB) begin
                doutB_r <= mem_r[addrBS2_r];
                opB_r <= `DPS_OP_READ;
                drvB_r <= 1'b1;
            end
        end
    end
    // Pin drivers follow output enables without a clock
    assign port_a_data_bus_out = doutA_r;
    assign port_b_data_bus_out = doutB_r;
    assign port_a_data_bus_oe = !port_a_output_enable_n && drvA_r;
    assign port_b_data_bus_oe = !port_b_output_enable_n && drvB_r;
    assign powerDown = powerDown_r;
    // Forwarded A-to-B words are also queued for a downstream consumer while the queue is not full
    dps_fifo #(
        .WIDTH(`DPS_FIFO_W),
        .DEPTH(`DPS_FIFO_D),
        .AW(`DPS_FIFO_AW)
    ) uFwdFifo (
        .clk(clk),
        .rst(rst),
        .inValid(fwdAB),
        .inReady(fwdInReady),
        .inData(dinAS2_r),
        .outValid(fwdValid),
        .outReady(fwdReady),
        .outData(fwdData)
    );
endmodule
`default_nettype wire

// >>> dv/dps_sva.sv
// Pin-level assertion checker for the dual-port memory
`timescale 1ns/100ps
`default_nettype none
`include "dps_regs.vh"
module dps_sva (
    input wire logic clk, rst, chip_select_low_active, chip_select_high_active,
    input wire logic forward_a_to_b_n, forward_b_to_a_n, powerDown, fwdValid, fwdReady,
    input wire logic port_a_output_enable_n, port_b_output_enable_n,
    input wire logic port_a_data_bus_oe, port_b_data_bus_oe,
    input wire logic [`DPS_DATA_W-1:0] port_a_data_bus_in, port_a_data_bus_out,
    input wire logic [`DPS_DATA_W-1:0] port_b_data_bus_in, port_b_data_bus_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Decoded controls of the sampled cycle
    wire sel = !chip_select_low_active && chip_select_high_active;
    wire fab = sel && !forward_a_to_b_n;
    wire fba = sel && !forward_b_to_a_n;
    a_oe_a_gate: assert property (port_a_output_enable_n |-> !port_a_data_bus_oe)
        else $error("port A drives while disabled");
    a_oe_b_gate: assert property (port_b_output_enable_n |-> !port_b_data_bus_oe)
        else $error("port B drives while disabled");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> powerDown
        && !port_a_data_bus_oe && !port_b_data_bus_oe) else $error("outputs active in reset");
    a_deselect_down: assert property (!sel |-> ##[3:4] powerDown)
        else $error("deselect without power-down");
    a_fwd_a_to_b: assert property (fab |-> ##3 port_b_data_bus_out == $past(port_a_data_bus_in, 3))
        else $error("A to B forward wrong");
    a_fwd_b_to_a: assert property (fba |-> ##3 port_a_data_bus_out == $past(port_b_data_bus_in, 3))
        else $error("B to A forward wrong");
    a_read_held_a: assert property (fab && !fba |-> ##3 $stable(port_a_data_bus_out))
        else $error("port A read during forward");
    a_read_held_b: assert property (fba && !fab |-> ##3 $stable(port_b_data_bus_out))
        else $error("port B read during forward");
    c_both_fwd: cover property (fab && fba);
    c_deselect: cover property (!sel);
    c_fifo_pop: cover property (fwdValid && fwdReady);
endmodule
bind dps_sram dps_sva i_dps_sva (.*);
`default_nettype wire

// >>> dv/dps_ctl_model.sv
// Controller-side model of one data port: enable policy and bus level
`timescale 1ns/100ps
`default_nettype none
`include "dps_regs.vh"
module dps_ctl_model (
    input wire logic clk, drive, devOe,
    input wire logic [`DPS_DATA_W-1:0] wrData, devOut,
    output logic oeN,
    output logic [`DPS_DATA_W-1:0] busIn
);
    logic [`DPS_DATA_W-1:0] lastBus = 36'h0; // Last level seen on the bus
    // Output enable held high while the controller drives data
    assign oeN = drive;
    // A released bus shows the inverted last level, never a stale copy
    assign busIn = devOe ? devOut : (drive ? wrData : ~lastBus);
    always @(posedge clk) lastBus <= busIn;
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the dual-port memory
`timescale 1ns/100ps
`default_nettype none
`include "dps_regs.vh"
module tb;
    // Controls packed as select low, select high, writes A B, forwards A B
    logic clk = 0, rst = 1, fwdReady = 0;
    logic [5:0] ctl = 6'h3F;
    logic [14:0] adA = 0, adB = 0;
    logic [35:0] wdA = 0, wdB = 0, dinA, dinB, doutA, doutB, fwdData;
    logic oeA, oeB, oeNA, oeNB, powerDown, fwdValid, fwdInReady;
    int miscompares = 0, checks_done = 0, i;
    always #2 clk = ~clk;
    dps_sram i_dps_sram (.clk(clk), .rst(rst), .chip_select_low_active(ctl[5]),
        .chip_select_high_active(ctl[4]), .port_a_write_enable_n(ctl[3]),
        .port_b_write_enable_n(ctl[2]), .forward_a_to_b_n(ctl[1]), .forward_b_to_a_n(ctl[0]),
        .port_a_output_enable_n(oeNA), .port_b_output_enable_n(oeNB), .port_a_address(adA),
        .port_b_address(adB), .port_a_data_bus_in(dinA), .port_a_data_bus_out(doutA),
        .port_a_data_bus_oe(oeA), .port_b_data_bus_in(dinB), .port_b_data_bus_out(doutB),
        .port_b_data_bus_oe(oeB), .powerDown(powerDown), .fwdValid(fwdValid),
        .fwdReady(fwdReady), .fwdData(fwdData), .fwdInReady(fwdInReady));
    dps_ctl_model i_dps_ctl_model_a (.clk(clk), .drive(!(ctl[3] && ctl[1])), .devOe(oeA),
        .wrData(wdA), .devOut(doutA), .oeN(oeNA), .busIn(dinA));
    dps_ctl_model i_dps_ctl_model_b (.clk(clk), .drive(!(ctl[2] && ctl[0])), .devOe(oeB),
        .wrData(wdB), .devOut(doutB), .oeN(oeNB), .busIn(dinB));
    // Compare one value and count it
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // One cycle of controls, applied at the falling edge
    task drv(input logic [5:0] c, input logic [14:0] a, b, input logic [35:0] x, y);
        ctl = c; adA = a; adB = b; wdA = x; wdB = y;
        @(negedge clk);
    endtask
    // One operation, then deselect until its outputs have landed
    task op(input logic [5:0] c, input logic [14:0] a, b, input logic [35:0] x, y);
        drv(c, a, b, x, y);
        drv(6'h3F, a, b, x, y);
        repeat (3) @(negedge clk);
    endtask
    task end_of_test;
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        chk(oeA | oeB, 36'h0);
        rst = 0;
        op(6'h13, 15'h1, 15'h2, 36'hA1, 36'hB2);
        op(6'h1F, 15'h2, 15'h1, 36'h0, 36'h0);
        chk(doutA, 36'hB2);
        chk(doutB, 36'hA1);
        chk(oeA, 36'h1);
        op(6'h13, 15'h5, 15'h5, 36'hC3, 36'hD4);
        op(6'h17, 15'h5, 15'h5, 36'hE5, 36'h0);
        chk(doutB, 36'hD4);
        op(6'h1F, 15'h5, 15'h5, 36'h0, 36'h0);
        chk(doutA, 36'hE5);
        op(6'h1C, 15'h0, 15'h0, 36'h66, 36'h77);
        chk(doutB, 36'h66);
        chk(doutA, 36'h77);
        // Back-to-back forwards with the consumer stalled fill the queue
        for (i = 1; i < 5; i++) drv(6'h1D, 15'h5, 15'h5, 36'h100 + i, 36'h0);
        op(6'h3F, 15'h0, 15'h0, 36'h0, 36'h0);
        chk(doutA, 36'h77);
        chk(doutB, 36'h104);
        chk(fwdInReady, 36'h0);
        op(6'h1E, 15'h5, 15'h5, 36'h0, 36'h88);
        chk(doutB, 36'h104);
        chk(doutA, 36'h88);
        fwdReady = 1;
        for (i = 0; i < 4; i++) begin
            chk(fwdData, i ? 36'h100 + i : 36'h66);
            @(negedge clk);
        end
        fwdReady = 0;
        chk(fwdValid, 36'h0);
        // Writes under either deselect form must not reach the array
        for (i = 0; i < 2; i++) begin
            op(i ? 6'h07 : 6'h37, 15'h1, 15'h1, 36'hEE, 36'h0);
            op(6'h1F, 15'h1, 15'h1, 36'h0, 36'h0);
            chk(doutA, 36'hA1);
        end
        end_of_test;
    end
endmodule
`default_nettype wire
